// ### design/adc_config_scan_control.sv
// adc_config_scan_control: two-wire slave, byte decode, scan and power control
// assumes scl/sda pins are asynchronous and open drain with pull-ups outside
//
// Behaviour
// - written byte with msb zero is the configuration byte
// - written byte with msb one is the setup byte
// - scan 00 converts channel zero up to selected channel
// - scan 01 converts selected channel eight times
// - scan 10 repeats channel zero to selected channel without end
// - scan 11 converts selected channel once
// - channel bits 4 and 3 both set enable monitor data read-back
// - config bit 0 picks single-ended, else differential pairs 0/1, 2/3
// - single-ended forces unipolar, polarity bit ignored
// - address with write bit acknowledged only when it matches
// - reset request returns configuration to power-up value
// - monitor bit set accepts up to 13 more bytes, each acknowledged
// - stop or repeated start may end monitor bytes early
// - stop returns high-speed interface to standard/fast mode
// - external clock: idle only after stop, nack or repeated start
// - internal clock: power down once all results are stored
// - idle device powers up on a valid address byte
// - reference pin channel skipped in scans 00 and 10 when it is a reference
// - results stored and returned in conversion order
// - read addressing starts the chosen scan sequence
// - setup bit 1 low resets configuration, setup kept
// - setup bit 0 extends write; bit 3 picks conversion clock
// - single-ended channel bits name the input directly
`timescale 1ns/1ps
module adc_config_scan_control
   import adc_ctl_pkg::*;
(
   // clock and reset
   input  wire logic                          mclk_in,
   input  wire logic                          rst_in,
   // two-wire bus pins
   input  wire logic                          scl_in,
   input  wire logic                          sda_in,
   output logic                               sda_out,
   output logic                               sda_oe_out,
   // address strap
   input  wire logic [6:0]                    dev_addr_in,
   // converter macro
   output logic                               conv_start_out,
   output logic [adc_ctl_pkg::CH_W-1:0]       conv_channel_out,
   output logic                               conv_diff_out,
   output logic                               conv_bipolar_out,
   output logic                               conv_ext_clock_out,
   input  wire logic                          conv_done_in,
   input  wire logic [adc_ctl_pkg::RES_W-1:0] conv_result_in,
   // power and mode status
   output logic                               conv_power_out,
   output logic                               ref_power_out,
   output logic                               ref_pin_is_ref_out,
   output logic                               hs_mode_out,
   // result memory read
   input  wire logic                          result_pop_in,
   output logic [adc_ctl_pkg::ENT_W-1:0]      result_data_out,
   output logic [adc_ctl_pkg::CNT_W-1:0]      result_count_out,
   // monitor-setup read-back
   output logic                               mon_readback_out,
   input  wire logic [adc_ctl_pkg::MON_W-1:0] mon_rd_idx_in,
   output logic [7:0]                         mon_rd_data_out
);
   import adc_ctl_pkg::*;

   typedef enum logic [2:0] {
      BS_IDLE    = 3'b000,
      BS_ADDR    = 3'b001,
      BS_ADDR_AK = 3'b010,
      BS_WR      = 3'b011,
      BS_WR_AK   = 3'b100,
      BS_RD      = 3'b101
   } bus_state_t;

   logic [8:0]        sync_q;
   logic              scl_s;
   logic              sda_s;
   logic [6:0]        addr_s;
   logic              scl_p_r;
   logic              sda_p_r;
   logic              start_c;
   logic              stop_c;
   logic              rise_c;
   logic              fall_c;

   bus_state_t        state_r, state_nxt;
   logic [3:0]        bit_r, bit_nxt;
   logic [7:0]        shift_r, shift_nxt;
   logic              drive_r, drive_nxt;
   logic              ack_r, ack_nxt;
   logic              hs_r, hs_nxt;
   logic              hs_code_r, hs_code_nxt;
   logic [7:0]        cfg_r, cfg_nxt;
   logic [7:0]        set_r, set_nxt;
   logic [3:0]        ext_r, ext_nxt;
   logic [MON_W-1:0]  mwr_r, mwr_nxt;
   logic              pwr_r, pwr_nxt;
   logic              seq_go;
   logic              seq_stop;
   logic              seq_done;
   logic              seq_busy;
   logic              mon_we;
   logic [7:0]        mon_mem [MON_BYTES];
   logic [7:0]        mon_data_r;
   logic [7:0]        rx_byte;
   logic              addr_hit;
   logic              is_hs_code;
   logic              ext_clk;

   // pins cross into mclk domain
   sync_2ff #(
      .W (9)
   ) u_sync (
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .d_in    ({dev_addr_in, sda_in, scl_in}),
      .q_out   (sync_q)
   );

   assign scl_s  = sync_q[0];
   assign sda_s  = sync_q[1];
   assign addr_s = sync_q[8:2];

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         scl_p_r <= 1'b1;
         sda_p_r <= 1'b1;
      end else begin
         scl_p_r <= scl_s;
         sda_p_r <= sda_s;
      end
   end

   assign start_c = scl_s && scl_p_r && sda_p_r && !sda_s;
   assign stop_c  = scl_s && scl_p_r && !sda_p_r && sda_s;
   assign rise_c  = scl_s && !scl_p_r;
   assign fall_c  = !scl_s && scl_p_r;

   assign rx_byte    = shift_r;
   assign addr_hit   = (rx_byte[7:1] == addr_s);
   assign is_hs_code = (rx_byte[7:3] == HS_CODE);
   assign ext_clk    = set_r[SET_EXT_CLK];

   always_comb begin
      state_nxt   = state_r;
      bit_nxt     = bit_r;
      shift_nxt   = shift_r;
      drive_nxt   = drive_r;
      ack_nxt     = ack_r;
      hs_nxt      = hs_r;
      hs_code_nxt = hs_code_r;
      cfg_nxt     = cfg_r;
      set_nxt     = set_r;
      ext_nxt     = ext_r;
      mwr_nxt     = mwr_r;
      pwr_nxt     = pwr_r;
      seq_go      = 1'b0;
      seq_stop    = 1'b0;
      mon_we      = 1'b0;
      // ack clock must not shift out the r/w bit
      if (rise_c && bit_r < BITS_BYTE && state_r != BS_ADDR_AK && state_r != BS_WR_AK) begin
         shift_nxt = {shift_r[6:0], sda_s};
      end
      if (rise_c) begin
         bit_nxt = bit_r + 4'h1;
      end
      unique case (state_r)
         BS_IDLE: ;
         BS_ADDR: begin
            if (fall_c && bit_r == BITS_BYTE) begin
               bit_nxt     = '0;
               hs_code_nxt = is_hs_code && !hs_r;
               ack_nxt     = addr_hit;
               drive_nxt   = addr_hit;
               state_nxt   = addr_hit ? BS_ADDR_AK : BS_IDLE;
               if (is_hs_code && !hs_r) begin
                  state_nxt = BS_ADDR_AK;
                  drive_nxt = 1'b0;
               end
               if (addr_hit) begin
                  pwr_nxt = 1'b1;
               end
            end
         end
         BS_ADDR_AK: begin
            if (fall_c) begin
               drive_nxt = 1'b0;
               bit_nxt   = '0;
               if (hs_code_r) begin
                  hs_nxt      = 1'b1;
                  hs_code_nxt = 1'b0;
                  state_nxt   = BS_IDLE;
               end else if (shift_r[0]) begin
                  seq_go    = 1'b1;
                  state_nxt = BS_RD;
               end else begin
                  state_nxt = BS_WR;
               end
            end
         end
         BS_WR: begin
            if (fall_c && bit_r == BITS_BYTE) begin
               bit_nxt   = '0;
               drive_nxt = 1'b1;
               state_nxt = BS_WR_AK;
               if (ext_r != '0) begin
                  mon_we  = 1'b1;
                  mwr_nxt = mwr_r + 4'h1;
                  ext_nxt = ext_r - 4'h1;
               end else if (rx_byte[BYTE_MSB]) begin
                  set_nxt = rx_byte;
                  if (!rx_byte[SET_RESET_N]) begin
                     cfg_nxt = CFG_RST;
                  end
                  if (rx_byte[SET_MON]) begin
                     ext_nxt = MON_BYTES;
                     mwr_nxt = '0;
                  end
               end else begin
                  cfg_nxt = rx_byte;
               end
            end
         end
         BS_WR_AK: begin
            if (fall_c) begin
               drive_nxt = 1'b0;
               bit_nxt   = '0;
               state_nxt = BS_WR;
            end
         end
         BS_RD: begin
            if (rise_c && bit_r == BITS_RD - 4'h1) begin
               bit_nxt = '0;
               if (sda_s) begin
                  state_nxt = BS_IDLE;
                  if (ext_clk) begin
                     seq_stop = 1'b1;
                     pwr_nxt  = 1'b0;
                  end
               end
            end
         end
         default: state_nxt = BS_IDLE;
      endcase
      if (seq_done && !ext_clk && cfg_r[CFG_SCAN_HI:CFG_SCAN_LO] != SCAN_MON) begin
         pwr_nxt = 1'b0;
      end
      if (stop_c) begin
         state_nxt = BS_IDLE;
         drive_nxt = 1'b0;
         ext_nxt   = '0;
         hs_nxt    = 1'b0;
      end
      if (start_c) begin
         state_nxt = BS_ADDR;
         bit_nxt   = '0;
         drive_nxt = 1'b0;
         ext_nxt   = '0;
      end
      if ((stop_c || (start_c && state_r != BS_IDLE)) && ext_clk) begin
         seq_stop = 1'b1;
         pwr_nxt  = 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_r   <= BS_IDLE;
         bit_r     <= '0;
         shift_r   <= '0;
         drive_r   <= 1'b0;
         ack_r     <= 1'b0;
         hs_r      <= 1'b0;
         hs_code_r <= 1'b0;
         cfg_r     <= CFG_RST;
         set_r     <= SET_RST;
         ext_r     <= '0;
         mwr_r     <= '0;
         pwr_r     <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         bit_r     <= bit_nxt;
         shift_r   <= shift_nxt;
         drive_r   <= drive_nxt;
         ack_r     <= ack_nxt;
         hs_r      <= hs_nxt;
         hs_code_r <= hs_code_nxt;
         cfg_r     <= cfg_nxt;
         set_r     <= set_nxt;
         ext_r     <= ext_nxt;
         mwr_r     <= mwr_nxt;
         pwr_r     <= pwr_nxt;
      end
   end

   // monitor-setup byte store
   always_ff @(posedge mclk_in) begin
      if (mon_we) begin
         mon_mem[mwr_r] <= rx_byte;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         mon_data_r <= '0;
      end else if (mon_rd_idx_in < MON_BYTES) begin
         mon_data_r <= mon_mem[mon_rd_idx_in];
      end else begin
         mon_data_r <= '0;
      end
   end

   scan_sequencer u_seq (
      .mclk_in          (mclk_in),
      .rst_in           (rst_in),
      .start_in         (seq_go),
      .stop_in          (seq_stop),
      .scan_mode_in     (cfg_r[CFG_SCAN_HI:CFG_SCAN_LO]),
      .chan_sel_in      (cfg_r[CFG_CS_HI:CFG_CS_LO]),
      .skip_ref_in      (set_r[SET_REFERENCE_SELECT_LO]),
      .done_out         (seq_done),
      .busy_out         (seq_busy),
      .conv_start_out   (conv_start_out),
      .conv_channel_out (conv_channel_out),
      .conv_done_in     (conv_done_in),
      .conv_result_in   (conv_result_in),
      .pop_in           (result_pop_in),
      .data_out         (result_data_out),
      .count_out        (result_count_out)
   );

   // open drain: only ever pulls low
   assign sda_out            = 1'b0;
   assign sda_oe_out         = drive_r;
   assign conv_diff_out      = !cfg_r[CFG_SE];
   assign conv_bipolar_out   = set_r[SET_BIP] && !cfg_r[CFG_SE];
   assign conv_ext_clock_out = ext_clk;
   assign conv_power_out     = pwr_r || seq_busy;
   assign ref_power_out      = set_r[SET_REF_PWR];
   assign ref_pin_is_ref_out = set_r[SET_REFERENCE_SELECT_LO];
   assign hs_mode_out        = hs_r;
   assign mon_readback_out   = cfg_r[CFG_CS3] && cfg_r[CFG_CS2];
   assign mon_rd_data_out    = mon_data_r;
endmodule : adc_config_scan_control

// ### inc/adc_ctl_pkg.sv
// adc_ctl_pkg: shared constants for the converter control block
// assumes a single 40 MHz system clock and an external converter macro
package adc_ctl_pkg;
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned RES_W  = 12;
   localparam int unsigned CH_W   = 2;
   localparam int unsigned ENT_W  = CH_W + RES_W;
   localparam int unsigned DEPTH  = 8;
   localparam int unsigned IDX_W  = 3;
   localparam int unsigned CNT_W  = 4;

   // configuration byte fields and power-up value
   localparam logic [7:0] CFG_RST      = 8'h01;
   localparam int unsigned CFG_SCAN_HI = 6;
   localparam int unsigned CFG_SCAN_LO = 5;
   localparam int unsigned CFG_CS3     = 4;
   localparam int unsigned CFG_CS2     = 3;
   localparam int unsigned CFG_CS_HI   = 2;
   localparam int unsigned CFG_CS_LO   = 1;
   localparam int unsigned CFG_SE      = 0;

   // setup byte fields and power-up value
   localparam logic [7:0] SET_RST      = 8'h82;
   localparam int unsigned BYTE_MSB    = 7;
   localparam int unsigned SET_SEL1    = 6;
   localparam int unsigned SET_REFERENCE_SELECT_LO    = 5;
   localparam int unsigned SET_REF_PWR = 4;
   localparam int unsigned SET_EXT_CLK = 3;
   localparam int unsigned SET_BIP     = 2;
   localparam int unsigned SET_RESET_N = 1;
   localparam int unsigned SET_MON     = 0;

   // extended monitor-setup bytes
   localparam logic [3:0] MON_BYTES = 4'hd;
   localparam int unsigned MON_W    = 4;

   // scan selections
   localparam logic [1:0] SCAN_RANGE  = 2'h0;
   localparam logic [1:0] SCAN_REPEAT = 2'h1;
   localparam logic [1:0] SCAN_MON    = 2'h2;
   localparam logic [1:0] SCAN_SINGLE = 2'h3;
   localparam logic [1:0] CH_REF      = 2'h3;
   localparam logic [2:0] REPEAT_LAST = 3'h7;

   // serial framing
   localparam logic [3:0] BITS_BYTE = 4'h8;
   localparam logic [3:0] BITS_RD   = 4'h9;
   localparam logic [4:0] HS_CODE   = 5'h01;
endpackage : adc_ctl_pkg

// ### design/sync_2ff.sv
// sync_2ff: two-flop synchroniser, one generate entry per bit
// assumes inputs are asynchronous to mclk_in
`timescale 1ns/1ps
module sync_2ff #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         rst_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic sync_r;
         always_ff @(posedge mclk_in) begin
            if (rst_in) begin
               meta_r <= 1'b1;
               sync_r <= 1'b1;
            end else begin
               meta_r <= d_in[i];
               sync_r <= meta_r;
            end
         end
         assign q_out[i] = sync_r;
      end
   endgenerate
endmodule : sync_2ff

// ### design/scan_sequencer.sv
// scan_sequencer: steps the converter through a scan and keeps results
// assumes the converter pulses conv_done_in once per started conversion
`timescale 1ns/1ps
module scan_sequencer
   import adc_ctl_pkg::*;
(
   // clock and reset
   input  wire logic                        mclk_in,
   input  wire logic                        rst_in,
   // control
   input  wire logic                        start_in,
   input  wire logic                        stop_in,
   input  wire logic [1:0]                  scan_mode_in,
   input  wire logic [adc_ctl_pkg::CH_W-1:0] chan_sel_in,
   input  wire logic                        skip_ref_in,
   output logic                             done_out,
   output logic                             busy_out,
   // converter
   output logic                             conv_start_out,
   output logic [adc_ctl_pkg::CH_W-1:0]     conv_channel_out,
   input  wire logic                        conv_done_in,
   input  wire logic [adc_ctl_pkg::RES_W-1:0] conv_result_in,
   // result read
   input  wire logic                        pop_in,
   output logic [adc_ctl_pkg::ENT_W-1:0]    data_out,
   output logic [adc_ctl_pkg::CNT_W-1:0]    count_out
);
   import adc_ctl_pkg::*;

   typedef enum logic [1:0] {
      SQ_IDLE  = 2'b00,
      SQ_START = 2'b01,
      SQ_WAIT  = 2'b10
   } sq_state_t;

   sq_state_t          state_r, state_nxt;
   logic [CH_W-1:0]    ch_r, ch_nxt;
   logic [IDX_W-1:0]   rep_r, rep_nxt;
   logic [IDX_W-1:0]   wr_r, wr_nxt;
   logic [IDX_W-1:0]   rd_r, rd_nxt;
   logic [CNT_W-1:0]   cnt_r, cnt_nxt;
   logic [ENT_W-1:0]   data_r, data_nxt;
   logic               done_r, done_nxt;
   logic [ENT_W-1:0]   mem [DEPTH];
   logic               last_ch;
   logic               single;

   assign single  = (scan_mode_in == SCAN_REPEAT) || (scan_mode_in == SCAN_SINGLE);
   assign last_ch = (ch_r == chan_sel_in) || (skip_ref_in && (ch_r + 2'h1 == CH_REF));

   always_comb begin
      state_nxt = state_r;
      ch_nxt    = ch_r;
      rep_nxt   = rep_r;
      wr_nxt    = wr_r;
      rd_nxt    = rd_r;
      cnt_nxt   = cnt_r;
      data_nxt  = data_r;
      done_nxt  = 1'b0;
      if (pop_in && cnt_r != '0) begin
         data_nxt = mem[rd_r];
         rd_nxt   = ({1'b0, rd_r} + 4'h1 == cnt_r) ? '0 : rd_r + 3'h1;
      end
      unique case (state_r)
         SQ_IDLE: ;
         SQ_START: state_nxt = SQ_WAIT;
         SQ_WAIT: begin
            if (conv_done_in) begin
               wr_nxt  = wr_r + 3'h1;
               cnt_nxt = (cnt_r == CNT_W'(DEPTH)) ? cnt_r : cnt_r + 4'h1;
               state_nxt = SQ_START;
               if (scan_mode_in == SCAN_REPEAT) begin
                  rep_nxt = rep_r + 3'h1;
                  if (rep_r == REPEAT_LAST) begin
                     state_nxt = SQ_IDLE;
                     done_nxt  = 1'b1;
                  end
               end else if (scan_mode_in == SCAN_SINGLE) begin
                  state_nxt = SQ_IDLE;
                  done_nxt  = 1'b1;
               end else if (!last_ch) begin
                  ch_nxt = ch_r + 2'h1;
               end else if (scan_mode_in == SCAN_MON) begin
                  ch_nxt = '0;
                  wr_nxt = '0;
               end else begin
                  state_nxt = SQ_IDLE;
                  done_nxt  = 1'b1;
               end
            end
         end
         default: state_nxt = SQ_IDLE;
      endcase
      if (start_in) begin
         state_nxt = SQ_START;
         ch_nxt    = single ? chan_sel_in : '0;
         rep_nxt   = '0;
         wr_nxt    = '0;
         rd_nxt    = '0;
         cnt_nxt   = '0;
      end else if (stop_in) begin
         state_nxt = SQ_IDLE;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_r <= SQ_IDLE;
         ch_r    <= '0;
         rep_r   <= '0;
         wr_r    <= '0;
         rd_r    <= '0;
         cnt_r   <= '0;
         data_r  <= '0;
         done_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ch_r    <= ch_nxt;
         rep_r   <= rep_nxt;
         wr_r    <= wr_nxt;
         rd_r    <= rd_nxt;
         cnt_r   <= cnt_nxt;
         data_r  <= data_nxt;
         done_r  <= done_nxt;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (state_r == SQ_WAIT && conv_done_in) begin
         mem[wr_r] <= {ch_r, conv_result_in};
      end
   end

   assign conv_start_out   = (state_r == SQ_START);
   assign conv_channel_out = ch_r;
   assign busy_out         = (state_r != SQ_IDLE);
   assign done_out         = done_r;
   assign data_out         = data_r;
   assign count_out        = cnt_r;
endmodule : scan_sequencer

// ### tb/adc_ctl_monitor.sv
// adc_ctl_monitor: port-level checks on the converter control block
// assumes a bind onto adc_config_scan_control, single clock domain
`timescale 1ns/1ps
module adc_ctl_monitor
   import adc_ctl_pkg::*;
(
   // clock, reset and bus pins
   input wire logic                          mclk_in,
   input wire logic                          rst_in,
   input wire logic                          scl_in,
   input wire logic                          sda_in,
   input wire logic                          sda_out,
   input wire logic                          sda_oe_out,
   // converter and status
   input wire logic                          conv_start_out,
   input wire logic                          conv_bipolar_out,
   input wire logic                          conv_diff_out,
   input wire logic                          conv_power_out,
   input wire logic                          hs_mode_out,
   input wire logic [adc_ctl_pkg::CNT_W-1:0] result_count_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   sequence s_ack_hold;
      sda_oe_out [*5];
   endsequence
   sequence s_bus_idle;
      scl_in && sda_in;
   endsequence
   AST_START_PULSE: assert property (conv_start_out |=> !conv_start_out)
      else $error("start pulse longer than one cycle");
   AST_START_POWER: assert property (conv_start_out |-> conv_power_out)
      else $error("conversion started while powered down");
   AST_BIPOLAR_DIFF: assert property (conv_bipolar_out |-> conv_diff_out)
      else $error("bipolar with single-ended input");
   AST_SDA_LOW: assert property (sda_oe_out |-> !sda_out)
      else $error("acknowledge drives a high level");
   AST_OE_SCL_LOW: assert property ($changed(sda_oe_out) |-> !$past(scl_in, 2))
      else $error("acknowledge changed in clock high");
   AST_OE_HOLD: assert property ($rose(sda_oe_out) |-> s_ack_hold)
      else $error("acknowledge too short");
   AST_HS_STOP: assert property ($fell(hs_mode_out) |-> s_bus_idle)
      else $error("high-speed left without stop");
   AST_COUNT_MAX: assert property (result_count_out <= 4'h8)
      else $error("result count above eight");
endmodule : adc_ctl_monitor

// ### tb/i2c_master_model.sv
// i2c_master_model: bus master making the serial clock, data pulled low
// assumes tasks are entered on a system-clock falling edge
`timescale 1ns/1ps
module i2c_master_model (
   // bus
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      pull_out
);
   initial begin
      scl_out = 1'b1;
      pull_out = 1'b0;
   end
   task automatic bitx(input logic b, output logic r);
      #50 pull_out = !b;
      #50 scl_out = 1'b1;
      #50 r = sda_in;
      #50 scl_out = 1'b0;
   endtask : bitx
   task automatic start_c();
      #50 pull_out = 1'b0;
      #50 scl_out = 1'b1;
      #100 pull_out = 1'b1;
      #100 scl_out = 1'b0;
   endtask : start_c
   task automatic stop_c();
      #50 pull_out = 1'b1;
      #50 scl_out = 1'b1;
      #100 pull_out = 1'b0;
   endtask : stop_c
   // msb first, ack on ninth clock
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(b[i], r);
      end
      bitx(1'b1, r);
      ack = !r;
   endtask : wbyte
endmodule : i2c_master_model

// ### tb/testbench.sv
// testbench: bus writes, scans and status checks on the control block
// assumes the master model and a 40 MHz clock; converter modelled here
`timescale 1ns/1ps
module testbench;
   import adc_ctl_pkg::*;
   // arbitrary strap address
   localparam logic [6:0] ADDR = 7'h2a;
   logic        mclk_in, rst_in, scl_in, sda_in, sda_out, sda_oe_out, m_pull, a;
   logic        conv_start_out, conv_diff_out, conv_bipolar_out, conv_ext_clock_out;
   logic        conv_done_in, conv_power_out, ref_power_out, ref_pin_is_ref_out;
   logic        hs_mode_out, result_pop_in, mon_readback_out;
   logic [1:0]  conv_channel_out, cs, ch, cq[$];
   logic [11:0] conv_result_in, res;
   logic [13:0] result_data_out, rq[$];
   logic [3:0]  result_count_out, mon_rd_idx_in;
   logic [7:0]  mon_rd_data_out, mb[13], q[$];
   logic [6:0]  dev_addr_in;
   int          failures, checks, dly, n, k;
   assign sda_in = !(m_pull | sda_oe_out);
   adc_config_scan_control DUT (.mclk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
      .dev_addr_in, .conv_start_out, .conv_channel_out, .conv_diff_out, .conv_bipolar_out,
      .conv_ext_clock_out, .conv_done_in, .conv_result_in, .conv_power_out, .ref_power_out,
      .ref_pin_is_ref_out, .hs_mode_out, .result_pop_in, .result_data_out,
      .result_count_out, .mon_readback_out, .mon_rd_idx_in, .mon_rd_data_out);
   i2c_master_model bfm (.sda_in, .scl_out(scl_in), .pull_out(m_pull));
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic finish_test();
      if (failures == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   task automatic wr(input logic [7:0] d[$]);
      bfm.start_c();
      bfm.wbyte({ADDR, 1'b0}, a);
      chk("addr ack", 1, a);
      foreach (d[i]) begin
         bfm.wbyte(d[i], a);
         chk("byte ack", 1, a);
      end
      bfm.stop_c();
      repeat (4) @(negedge mclk_in);
   endtask : wr
   // expected channel order, then read addressing starts the scan
   task automatic scan(input logic [1:0] m, input logic [1:0] c, input int skip);
      k = c + 1 - skip;
      n = (m == 2'h1) ? 8 : (m == 2'h3) ? 1 : k;
      cq = {};
      rq = {};
      for (int i = 0; i < 40; i++) cq.push_back(m[0] ? c : 2'(i % k));
      bfm.start_c();
      bfm.wbyte({ADDR, 1'b1}, a);
      chk("read ack", 1, a);
      repeat (8) @(negedge mclk_in);
      for (int i = 0; i < 4000 && (m == 2'h2 ? rq.size() < 12 : conv_power_out); i++)
         @(negedge mclk_in);
      if (m == 2'h2) begin
         chk("monitor repeats", 1, rq.size() >= 12);
         rst_in = 1'b1;
         repeat (2) @(negedge mclk_in);
         {rst_in, dly} = 0;
      end else begin
         chk("power down", 0, conv_power_out);
         chk("count", n, result_count_out);
         for (int i = 0; i < n; i++) begin
            result_pop_in = 1'b1;
            @(negedge mclk_in);
            result_pop_in = 1'b0;
            chk("result", rq[i], result_data_out);
         end
      end
      bfm.stop_c();
      repeat (4) @(negedge mclk_in);
   endtask : scan
   // converter stand-in with random conversion time
   always @(negedge mclk_in) begin
      conv_done_in <= 1'b0;
      if (conv_start_out === 1'b1) begin
         ch = cq.size() ? cq.pop_front() : 2'h0;
         chk("channel", ch, conv_channel_out);
         dly = $urandom_range(6, 1);
         res = 12'($urandom);
      end else if (dly > 0) begin
         dly--;
         if (dly == 0) begin
            conv_done_in <= 1'b1;
            conv_result_in <= res;
            rq.push_back({ch, res});
         end
      end
   end
   initial begin
      void'($urandom(32'h347e4dfa));
      {rst_in, conv_done_in, result_pop_in, dly} = 0;
      rst_in = 1'b1;
      {conv_result_in, mon_rd_idx_in, dev_addr_in} = {12'h000, 4'h0, ADDR};
      repeat (16) @(negedge mclk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge mclk_in);
      chk("reset diff", 0, conv_diff_out);
      for (int m = 0; m < 4; m++) begin
         cs = 2'($urandom_range(3, 0));
         wr('{{1'b0, 2'(m), 2'h0, cs, 1'b1}});
         scan(2'(m), cs, 0);
      end
      wr('{8'h07, 8'ha2});
      chk("ref pin", 1, ref_pin_is_ref_out);
      chk("ref power", 0, ref_power_out);
      scan(2'h0, 2'h3, 1);
      wr('{8'h00, 8'ha6, 8'h8e});
      chk("bipolar", 1, conv_bipolar_out & conv_diff_out & conv_ext_clock_out);
      wr('{8'h84});
      chk("soft reset", 0, conv_bipolar_out | conv_diff_out);
      q = '{8'h19, 8'h83};
      foreach (mb[i]) begin
         mb[i] = 8'($urandom);
         q.push_back(mb[i]);
      end
      wr(q);
      chk("readback", 1, mon_readback_out);
      for (int i = 0; i < 14; i++) begin
         mon_rd_idx_in = 4'(i);
         repeat (2) @(negedge mclk_in);
         chk("monitor byte", i < 13 ? mb[i] : 8'h00, mon_rd_data_out);
      end
      wr('{8'h83, 8'h3c});
      wr('{8'h00});
      chk("early end", 0, mon_readback_out);
      bfm.start_c();
      bfm.wbyte({ADDR ^ 7'h01, 1'b0}, a);
      chk("foreign nack", 0, a);
      bfm.start_c();
      bfm.wbyte(8'h08, a);
      repeat (6) @(negedge mclk_in);
      chk("hs entry", 1, {a, hs_mode_out});
      bfm.stop_c();
      repeat (6) @(negedge mclk_in);
      chk("hs exit", 0, hs_mode_out);
      finish_test();
   end
   initial begin
      #2000000;
      failures++;
      finish_test();
   end
endmodule : testbench
bind adc_config_scan_control adc_ctl_monitor mon (.mclk_in, .rst_in, .scl_in, .sda_in,
   .sda_out, .sda_oe_out, .conv_start_out, .conv_bipolar_out, .conv_diff_out,
   .conv_power_out, .hs_mode_out, .result_count_out);
